//--- dv/ezt_disp_model.sv
// Model of the shader dispatcher that receives surviving subspans
`timescale 1ns/1ns
module ezt_disp_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       disp_valid,
  input  wire logic [3:0] disp_mask,
  output logic      [7:0] disp_cnt_q,
  output logic      [7:0] empty_cnt_q
);
  // ****************************
  // Thread intake
  // ****************************
  // No back-pressure: the stage stalls only on ce, which this model ignores
  always_ff @(posedge clk) begin
    if (rst) begin
      disp_cnt_q  <= 8'h00;
      empty_cnt_q <= 8'h00;
    end else if (disp_valid) begin
      disp_cnt_q <= disp_cnt_q + 8'h01;
      if (disp_mask == 4'h0) begin
        empty_cnt_q <= empty_cnt_q + 8'h01;
      end
    end
  end
endmodule

//--- dv/ezt_top_tb.sv
// Self-checking bench for the early depth/stencil stage
`timescale 1ns/1ns
`include "ezt_defs.svh"
module ezt_top_tb;
  import ezt_pkg::*;
  // ****************************
  // Signals
  // ****************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        prim_valid = 1'b0;
  ezt_prim_t   prim = '0;
  logic        bias_valid;
  logic [31:0] bias;
  logic [31:0] z_biased;
  logic        ss_valid = 1'b0;
  ezt_ss_t     ss = '0;
  logic        disp_valid;
  logic [3:0]  disp_mask;
  logic [3:0]  early_wr;
  ezt_pay_t    pay;
  ezt_mode_t   mode;
  logic [7:0]  disp_cnt;
  logic [7:0]  empty_cnt;
  logic [31:0] rdat;
  logic        rerr;
  int          error_cnt = 0;
  int          check_count = 0;
  int          exp_disp = 0;
  localparam logic [31:0] c_bias  = 32'h0001;
  localparam logic [31:0] c_leg   = 32'h0002;
  localparam logic [31:0] c_fz    = 32'h0004;
  localparam logic [31:0] c_early = 32'h0008;
  localparam logic [31:0] c_stat  = 32'h0010;
  localparam logic [31:0] c_kill  = 32'h0020;
  localparam logic [31:0] c_alpha = 32'h0040;
  localparam logic [31:0] c_cd    = 32'h0080;
  localparam logic [31:0] c_src   = 32'h0100;
  localparam logic [31:0] c_st    = 32'h0200;
  localparam logic [31:0] c_sw    = 32'h0400;
  localparam logic [31:0] c_dt    = 32'h0800;
  localparam logic [31:0] c_dw    = 32'h1000;
  localparam logic [31:0] c_null  = 32'h2000;
  // Coefficient read offset software programs; position in element 0
  localparam int pos_elem    = 0;
  localparam int coef_rd_ofs = pos_elem * 2 + 1;

  always #4 clk = ~clk;

  // Clock enable dropped once to check that the stage freezes
  ezt_top #(.ADDR_W(8)) u_dut (
    .clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .prim_valid(prim_valid), .prim(prim), .bias_valid(bias_valid),
    .bias(bias), .z_biased(z_biased),
    .ss_valid(ss_valid), .ss(ss), .disp_valid(disp_valid),
    .disp_mask(disp_mask), .early_wr(early_wr), .pay(pay), .mode(mode)
  );

  ezt_disp_model u_disp (
    .clk(clk), .rst(rst), .disp_valid(disp_valid),
    .disp_mask(disp_mask), .disp_cnt_q(disp_cnt),
    .empty_cnt_q(empty_cnt)
  );

  // ****************************
  // Shared tasks
  // ****************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Fixed slopes: |dx| beats |dy| only by magnitude, z = 1.0
  task automatic pb(input logic t, input logic [31:0] mz,
                    input logic [31:0] eb, input logic [31:0] ez);
    @(posedge clk);
    prim_valid <= 1'b1;
    prim <= '{t, 32'hBF000000, 32'h3E800000, 32'h3F800000, mz};
    @(posedge clk);
    prim_valid <= 1'b0;
    #1;
    check(32'(bias_valid), 32'h1);
    check(bias, eb);
    check(z_biased, ez);
  endtask

  task automatic sub(input logic [31:0] ctl, input logic [3:0] m,
                     input logic [3:0] df, input logic [3:0] sf,
                     input ezt_mode_t em, input logic [3:0] emk,
                     input logic [3:0] ewr);
    wr(`EZT_REG_CTRL, ctl);
    @(posedge clk);
    ss_valid <= 1'b1;
    ss <= '{m, df, sf};
    @(posedge clk);
    ss_valid <= 1'b0;
    #1;
    check(32'(mode), 32'(em));
    check(32'(disp_valid), 32'(emk != 4'h0));
    check(32'(disp_mask), 32'(emk));
    check(32'(early_wr), 32'(ewr));
    if (emk != 4'h0) begin
      exp_disp++;
    end
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_regs();
    apb(1'b0, `EZT_REG_CTRL, 32'h0);
    check(rdat, 32'h0);
    wr(`EZT_REG_CTRL, 32'hFFFFFFFF);
    apb(1'b0, `EZT_REG_CTRL, 32'h0);
    check(rdat, 32'h00003FFF);
    apb(1'b0, 8'h18, 32'h0);
    check(32'(rerr), 32'h1);
    check(rdat, 32'h0);
  endtask

  task automatic t_bias();
    wr(`EZT_REG_UNIT, 32'h3F000000);
    wr(`EZT_REG_CONST, 32'h40000000);
    wr(`EZT_REG_SCALE, 32'h3F800000);
    wr(`EZT_REG_CLAMP, 32'h0);
    wr(`EZT_REG_CTRL, c_bias);
    pb(1'b1, 32'h0, 32'h3FC00000, 32'h40200000);
    pb(1'b0, 32'h0, 32'h0, 32'h3F800000);
    wr(`EZT_REG_CTRL, c_bias | c_leg);
    pb(1'b1, 32'h0, 32'h40200000, 32'h40600000);
    wr(`EZT_REG_CTRL, c_bias | c_fz);
    pb(1'b1, 32'h4B000000, 32'h40200000, 32'h40600000);
    wr(`EZT_REG_CTRL, c_bias | c_fz | c_leg);
    pb(1'b1, 32'h4B800000, 32'h40200000, 32'h40600000);
  endtask

  task automatic t_clamp();
    wr(`EZT_REG_CTRL, c_bias);
    wr(`EZT_REG_CLAMP, 32'h3F800000);
    pb(1'b1, 32'h0, 32'h3F800000, 32'h40000000);
    wr(`EZT_REG_CONST, 32'hC0000000);
    wr(`EZT_REG_CLAMP, 32'hBE800000);
    apb(1'b0, `EZT_REG_CLAMP, 32'h0);
    check(rdat, 32'hBE800000);
    pb(1'b1, 32'h0, 32'hBE800000, 32'h3F400000);
  endtask

  task automatic t_early();
    sub(c_early, 4'hF, 4'hF, 4'hF, ezt_mode_early, 4'hF, 4'h0);
    sub(c_early | c_null | c_dt | c_dw, 4'hF, 4'hF, 4'h0,
        ezt_mode_early, 4'hF, 4'h0);
    sub(c_early | c_dt, 4'h5, 4'h1, 4'h0, ezt_mode_early, 4'h4, 4'h0);
    sub(c_early | c_dt, 4'hF, 4'hF, 4'h0, ezt_mode_early, 4'h0, 4'h0);
    sub(c_early | c_dw, 4'hF, 4'h0, 4'h0, ezt_mode_early, 4'hF, 4'hF);
  endtask

  task automatic t_late();
    sub(c_early | c_dw | c_kill, 4'hF, 4'h0, 4'h0,
        ezt_mode_late_wr, 4'hF, 4'h0);
    sub(c_early | c_st | c_dt | c_dw | c_kill, 4'hF, 4'h1, 4'h2,
        ezt_mode_late_wr, 4'hC, 4'h0);
    sub(c_early | c_sw | c_dt | c_dw | c_kill, 4'hF, 4'h1, 4'h0,
        ezt_mode_late_wr, 4'hE, 4'h0);
    sub(c_early | c_sw, 4'hF, 4'h0, 4'h0, ezt_mode_early, 4'hF, 4'h0);
  endtask

  task automatic t_comp();
    sub(c_early | c_st | c_sw | c_dt | c_dw | c_kill, 4'hF, 4'hF, 4'h0,
        ezt_mode_computed, 4'hF, 4'h0);
    sub(c_early | c_cd | c_dt, 4'hF, 4'hF, 4'hF,
        ezt_mode_computed, 4'hF, 4'h0);
    sub(c_dt, 4'hF, 4'hF, 4'h0, ezt_mode_computed, 4'hF, 4'h0);
  endtask

  task automatic t_stats();
    sub(c_early | c_stat, 4'hF, 4'h0, 4'h0,
        ezt_mode_early, 4'hF, 4'h0);
    check(32'(pay.wo_alloc), 32'h0);
    sub(c_early | c_stat | c_alpha, 4'hF, 4'h0, 4'h0,
        ezt_mode_late_wr, 4'hF, 4'h0);
    check(32'(pay), 32'h19);
    apb(1'b0, `EZT_REG_STAT, 32'h0);
    check(rdat, 32'h00000065);
    sub(c_early | c_stat | c_kill | c_cd, 4'hF, 4'h0, 4'h0,
        ezt_mode_late_wr, 4'hF, 4'h0);
    check(32'(pay), 32'h09);
    sub(c_early | c_src, 4'hF, 4'h0, 4'h0,
        ezt_mode_early, 4'hF, 4'h0);
    check(32'(pay), 32'h10);
  endtask

  // Stage frozen for one cycle: the primitive is lost, outputs hold
  task automatic t_stall();
    @(posedge clk);
    ce <= 1'b0;
    prim_valid <= 1'b1;
    prim <= '{1'b1, 32'hBF000000, 32'h3E800000, 32'h3F800000, 32'h0};
    @(posedge clk);
    ce <= 1'b1;
    prim_valid <= 1'b0;
    #1;
    check(32'(bias_valid), 32'h0);
    check(bias, 32'hBE800000);
    check(z_biased, 32'h3F400000);
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bias();
    t_clamp();
    t_stall();
    t_early();
    t_late();
    t_comp();
    t_stats();
    repeat (2) @(posedge clk);
    check(32'(empty_cnt), 32'h0);
    check(32'(disp_cnt), 32'(exp_disp));
    check(32'(coef_rd_ofs), 32'h1);
    final_report();
  end
endmodule

//--- hw/ezt_defs.svh
// Constants for the early depth/stencil stage
`ifndef EZT_DEFS_SVH
`define EZT_DEFS_SVH
// ****************************
// Register offsets (byte)
// ****************************
`define EZT_REG_CTRL   8'h00
`define EZT_REG_UNIT   8'h04
`define EZT_REG_CONST  8'h08
`define EZT_REG_SCALE  8'h0C
`define EZT_REG_CLAMP  8'h10
`define EZT_REG_STAT   8'h14
// ****************************
// Control field positions
// ****************************
`define EZT_C_BIAS_EN  0
`define EZT_C_LEGACY   1
`define EZT_C_FLOAT_Z  2
`define EZT_C_EARLY    3
`define EZT_C_STATS    4
`define EZT_C_KILL     5
`define EZT_C_ALPHA    6
`define EZT_C_CDEPTH   7
`define EZT_C_USESRC   8
`define EZT_C_ST       9
`define EZT_C_SW       10
`define EZT_C_DT       11
`define EZT_C_DW       12
`define EZT_C_NULL     13
`define EZT_CTRL_W     14
// ****************************
// Float32 constants
// ****************************
`define EZT_FP_ONE     32'h3F800000
`define EZT_FP_ZERO    32'h00000000
`define EZT_MANT_W     8'h17
`define EZT_EXP_BIAS   10'h07F
`define EZT_EXP_MAX    10'h0FF
`endif

//--- hw/ezt_fadd.sv
// Float32 adder, truncating, denormals flushed to zero
`timescale 1ns/1ns
`include "ezt_defs.svh"
module ezt_fadd (
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic      [31:0] s
);
  wire        swap = b[30:0] > a[30:0];
  wire [31:0] x    = swap ? b : a;
  wire [31:0] y    = swap ? a : b;
  wire [7:0]  dexp = x[30:23] - y[30:23];
  wire [24:0] mx   = (x[30:23] == 8'h00) ? 25'h0 : {2'b01, x[22:0]};
  wire [24:0] my0  = (y[30:23] == 8'h00) ? 25'h0 : {2'b01, y[22:0]};
  wire [24:0] my   = (dexp > 8'h18) ? 25'h0 : (my0 >> dexp);
  wire [24:0] mag  = (x[31] == y[31]) ? mx + my : mx - my;
  logic [4:0] lead;
  logic [9:0] e_n;
  logic [24:0] m_n;

  // Normalise on the leading one
  always_comb begin
    lead = 5'h00;
    for (int i = 0; i < 25; i++) begin
      if (mag[i]) begin
        lead = 5'(i);
      end
    end
    m_n = mag << (5'h18 - lead);
    e_n = {2'b00, x[30:23]} + {5'h00, lead} - 10'h017;
  end

  assign s = (mag == 25'h0)                ? 32'h00000000 :
             (e_n[9] || e_n == 10'h000)    ? {x[31], 31'h00000000} :
             (e_n >= `EZT_EXP_MAX)         ? {x[31], 8'hFF, 23'h000000} :
             {x[31], e_n[7:0], m_n[23:1]};
endmodule

//--- hw/ezt_fmul.sv
// Float32 multiplier, truncating, denormals flushed to zero
`timescale 1ns/1ns
`include "ezt_defs.svh"
module ezt_fmul (
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic      [31:0] p
);
  wire        zero_in = (a[30:23] == 8'h00) || (b[30:23] == 8'h00);
  wire [47:0] prod    = {1'b1, a[22:0]} * {1'b1, b[22:0]};
  wire [9:0]  exp_raw = {2'b00, a[30:23]} + {2'b00, b[30:23]}
                        - `EZT_EXP_BIAS + {9'h000, prod[47]};
  wire [22:0] frac    = prod[47] ? prod[46:24] : prod[45:23];
  wire        sgn     = a[31] ^ b[31];

  // Underflow flushes; overflow saturates to infinity
  assign p = zero_in                      ? {sgn, 31'h00000000} :
             (exp_raw[9] || exp_raw == 10'h000) ? {sgn, 31'h00000000} :
             (exp_raw >= `EZT_EXP_MAX)    ? {sgn, 8'hFF, 23'h000000} :
             {sgn, exp_raw[7:0], frac};
endmodule

//--- hw/ezt_pkg.sv
// Types shared by the early depth/stencil stage
package ezt_pkg;
  typedef enum logic [1:0] {
    ezt_mode_computed = 2'b00,
    ezt_mode_late_wr  = 2'b01,
    ezt_mode_early    = 2'b10
  } ezt_mode_t;

  typedef struct packed {
    logic        is_tri;
    logic [31:0] dzdx;
    logic [31:0] dzdy;
    logic [31:0] z;
    logic [31:0] max_z;
  } ezt_prim_t;

  typedef struct packed {
    logic [3:0] mask;
    logic [3:0] depth_fail;
    logic [3:0] stencil_fail;
  } ezt_ss_t;

  typedef struct packed {
    logic src_present;
    logic src_to_rt;
    logic dst_depth;
    logic dst_stencil;
    logic wo_alloc;
  } ezt_pay_t;
endpackage

//--- hw/ezt_top.sv
// Early depth/stencil stage: depth bias, mode select, subspan culling
`timescale 1ns/1ns
`include "ezt_defs.svh"
// Functional notes
// - Depth bias applies to triangles only, never points or lines.
// - Max depth slope is the larger absolute x or y depth derivative.
// - Integer or absent depth buffer uses unit term; legacy forces 1.0.
// - Float depth scales constant by 2^(max z exponent - 23).
// - Float depth with legacy bit leaves the constant unscaled.
// - Positive clamp caps bias, negative floors it, zero leaves it.
// - No clamping of the biased depth at this stage.
// - One bias per primitive, all in float32 arithmetic.
// - Early discard only where the pixel cannot affect any buffer.
// - Partly killed subspan loses mask bits; fully killed is not dispatched.
// - Shader may discard: no early depth or stencil writes.
// - Shader writes depth: interpolated depth decides nothing.
// - Shader reads source depth: payload always carries it.
// - Computed mode tests and writes after shading; nothing killed early.
// - Depth fail does not kill outside early mode when a stencil write is indicated.
// - Late-write mode tests early, writes late, kills stencil fails.
// - Stencil writes turn late-write cases into computed mode.
// - Early mode does all depth/stencil before shading.
// - Null depth surface forces depth test, stencil test, depth write off.
// - Stencil write enable is gated by the qualified stencil test.
// - Statistics with kill and early mode force late-write and write-only.
// - In that override without shader depth, source depth goes in payload.
// - Source depth present whenever the shader reads it.
module ezt_top
  import ezt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // Primitive setup
  input  wire logic              prim_valid,
  input  wire ezt_pkg::ezt_prim_t prim,
  output logic                   bias_valid,
  output logic      [31:0]       bias,
  output logic      [31:0]       z_biased,
  // Subspans from the rasteriser with test results
  input  wire logic              ss_valid,
  input  wire ezt_pkg::ezt_ss_t  ss,
  output logic                   disp_valid,
  output logic      [3:0]        disp_mask,
  output logic      [3:0]        early_wr,
  output ezt_pkg::ezt_pay_t      pay,
  output ezt_pkg::ezt_mode_t     mode
);
  import ezt_pkg::*;

  if (ADDR_W < 5) begin : g_chk
    $error("ezt_top: ADDR_W too small for register map");
  end

  // ****************************
  // Float helper
  // ****************************
  function automatic logic fp_gt(input logic [31:0] a,
                                 input logic [31:0] b);
    logic r;
    r = 1'b0;
    if (!a[31] && !b[31]) begin
      r = a[30:0] > b[30:0];
    end else if (a[31] && b[31]) begin
      r = a[30:0] < b[30:0];
    end else if (!a[31]) begin
      r = (a[30:0] != 31'h0) || (b[30:0] != 31'h0);
    end
    return r;
  endfunction

  // ****************************
  // Registers
  // ****************************
  logic [`EZT_CTRL_W-1:0] ctrl_q;
  logic [31:0]            unit_q;
  logic [31:0]            const_q;
  logic [31:0]            scale_q;
  logic [31:0]            clamp_q;
  logic                   pready_q;
  logic [31:0]            prdata_q;
  logic                   pslverr_q;

  wire setup   = psel && !penable && !pready_q;
  wire wr_fire = psel && penable && pready_q && pwrite;
  wire [7:0] a8 = 8'(paddr);
  wire hit_ctrl  = a8 == `EZT_REG_CTRL;
  wire hit_unit  = a8 == `EZT_REG_UNIT;
  wire hit_const = a8 == `EZT_REG_CONST;
  wire hit_scale = a8 == `EZT_REG_SCALE;
  wire hit_clamp = a8 == `EZT_REG_CLAMP;
  wire hit_stat  = a8 == `EZT_REG_STAT;
  wire mapped = hit_ctrl || hit_unit || hit_const || hit_scale
                || hit_clamp || hit_stat;

  // ****************************
  // Mode selection
  // ****************************
  wire null_z = ctrl_q[`EZT_C_NULL];
  wire st  = ctrl_q[`EZT_C_ST] && !null_z;
  wire dt  = ctrl_q[`EZT_C_DT] && !null_z;
  wire dw  = ctrl_q[`EZT_C_DW] && !null_z;
  wire sw  = ctrl_q[`EZT_C_SW] && st;
  wire cd  = ctrl_q[`EZT_C_CDEPTH];
  wire kil = ctrl_q[`EZT_C_KILL] || ctrl_q[`EZT_C_ALPHA];
  wire early_en = ctrl_q[`EZT_C_EARLY];
  wire stats    = ctrl_q[`EZT_C_STATS];
  wire use_src  = ctrl_q[`EZT_C_USESRC];

  // Early-enabled table reduced to equations
  wire sw_early = !kil && (!cd || (!dt && !dw));
  wire en_early = sw ? sw_early :
                  (!dt && !dw) ? 1'b1 :
                  (!dt) ? !(cd || kil) :
                  !cd && !(kil && dw);
  wire en_comp  = sw || (dt && cd);
  wire dis_early = !st && !dt && !dw && !cd;
  wire tab_early = early_en ? en_early : dis_early;
  wire tab_comp  = early_en ? (!en_early && en_comp) : !dis_early;
  wire ovr = stats && kil && tab_early;

  ezt_mode_t mode_w;
  assign mode_w = ovr       ? ezt_mode_late_wr :
                  tab_early ? ezt_mode_early :
                  tab_comp  ? ezt_mode_computed :
                  ezt_mode_late_wr;

  wire is_p = mode_w == ezt_mode_early;
  wire is_c = mode_w == ezt_mode_computed;
  wire is_n = mode_w == ezt_mode_late_wr;

  ezt_pay_t pay_w;
  assign pay_w.src_present = use_src
                             || (ovr && !cd)
                             || (!is_p && !cd && (dt || dw));
  assign pay_w.src_to_rt   = ovr || (!is_p && (cd || dt || dw));
  assign pay_w.dst_depth   = is_c && dt;
  assign pay_w.dst_stencil = !is_p && st;
  assign pay_w.wo_alloc    = ovr;

  // ****************************
  // Pixel kill
  // ****************************
  // Computed mode kills nothing; the shader result is still unknown
  wire [3:0] dfail = dt && !cd ? ss.depth_fail : 4'h0;
  wire [3:0] sfail = st ? ss.stencil_fail : 4'h0;
  wire [3:0] kill_p = dfail | sfail;
  wire [3:0] kill_n = sw ? 4'h0 : (dfail | sfail);
  wire [3:0] kill_w = is_p ? kill_p :
                      is_n ? kill_n : 4'h0;
  wire [3:0] live_w = ss.mask & ~kill_w;
  wire       wr_ok  = is_p && !kil && (dw || sw);

  // ****************************
  // Depth bias datapath
  // ****************************
  wire [31:0] adzdx = {1'b0, prim.dzdx[30:0]};
  wire [31:0] adzdy = {1'b0, prim.dzdy[30:0]};
  wire [31:0] slope = (adzdx[30:0] > adzdy[30:0]) ? adzdx : adzdy;
  wire [7:0]  mz_e  = prim.max_z[30:23];
  wire [31:0] pow2  = (mz_e > `EZT_MANT_W)
                      ? {1'b0, 8'(mz_e - `EZT_MANT_W), 23'h000000}
                      : `EZT_FP_ZERO;
  wire [31:0] unit_w = ctrl_q[`EZT_C_LEGACY] ? `EZT_FP_ONE :
                       ctrl_q[`EZT_C_FLOAT_Z] ? pow2 : unit_q;
  logic [31:0] m_const;
  logic [31:0] m_slope;
  logic [31:0] raw_bias;
  logic [31:0] z_sum;

  ezt_fmul u_mul_const (
    .a (const_q),
    .b (unit_w),
    .p (m_const)
  );
  ezt_fmul u_mul_slope (
    .a (scale_q),
    .b (slope),
    .p (m_slope)
  );
  ezt_fadd u_add_bias (
    .a (m_const),
    .b (m_slope),
    .s (raw_bias)
  );

  wire clamp_pos = !clamp_q[31] && (clamp_q[30:0] != 31'h0);
  wire clamp_neg = clamp_q[31] && (clamp_q[30:0] != 31'h0);
  wire [31:0] clamped =
    (clamp_pos && fp_gt(raw_bias, clamp_q)) ? clamp_q :
    (clamp_neg && fp_gt(clamp_q, raw_bias)) ? clamp_q :
    raw_bias;
  wire apply = prim.is_tri && ctrl_q[`EZT_C_BIAS_EN];
  wire [31:0] bias_w = apply ? clamped : `EZT_FP_ZERO;

  // Result not clamped to [0,1]; that happens after interpolation
  ezt_fadd u_add_z (
    .a (prim.z),
    .b (bias_w),
    .s (z_sum)
  );

  // ****************************
  // APB slave
  // ****************************
  // Zero wait states: decoded in setup, answered in the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= !setup || pwrite ? 32'h00000000 :
                   hit_ctrl  ? {18'h00000, ctrl_q} :
                   hit_unit  ? unit_q :
                   hit_const ? const_q :
                   hit_scale ? scale_q :
                   hit_clamp ? clamp_q :
                   hit_stat  ? {25'h0000000, pay_w, mode_w} :
                   32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q  <= '0;
      unit_q  <= `EZT_FP_ZERO;
      const_q <= `EZT_FP_ZERO;
      scale_q <= `EZT_FP_ZERO;
      clamp_q <= `EZT_FP_ZERO;
    end else if (ce && wr_fire) begin
      if (hit_ctrl)  ctrl_q  <= pwdata[`EZT_CTRL_W-1:0];
      if (hit_unit)  unit_q  <= pwdata;
      if (hit_const) const_q <= pwdata;
      if (hit_scale) scale_q <= pwdata;
      if (hit_clamp) clamp_q <= pwdata;
    end
  end

  // ****************************
  // Output stages
  // ****************************
  always_ff @(posedge clk) begin
    if (rst) begin
      bias_valid <= 1'b0;
      bias       <= `EZT_FP_ZERO;
      z_biased   <= `EZT_FP_ZERO;
    end else if (ce) begin
      bias_valid <= prim_valid;
      if (prim_valid) begin
        bias     <= bias_w;
        z_biased <= z_sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      disp_valid <= 1'b0;
      disp_mask  <= 4'h0;
      early_wr   <= 4'h0;
      pay        <= '0;
      mode       <= ezt_mode_computed;
    end else if (ce) begin
      disp_valid <= ss_valid && (live_w != 4'h0);
      disp_mask  <= ss_valid ? live_w : 4'h0;
      early_wr   <= ss_valid && wr_ok ? live_w : 4'h0;
      pay        <= pay_w;
      mode       <= mode_w;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************
  // Assertions
  // ****************************
  property p_no_bias_nontri;
    @(posedge clk) disable iff (rst)
      ce && prim_valid && !prim.is_tri |=> bias == `EZT_FP_ZERO;
  endproperty
  a_no_bias_nontri: assert property (p_no_bias_nontri)
    else $error("bias applied to non-triangle");

  property p_null_surface;
    @(posedge clk) disable iff (rst)
      ce && null_z |=> early_wr == 4'h0 && !pay.dst_depth
                       && !pay.dst_stencil;
  endproperty
  a_null_surface: assert property (p_null_surface)
    else $error("tests active with null depth surface");

  property p_sw_qual;
    @(posedge clk) disable iff (rst)
      ce && ss_valid && !st && !dw |=> early_wr == 4'h0;
  endproperty
  a_sw_qual: assert property (p_sw_qual)
    else $error("stencil write without stencil test");

  property p_empty_drop;
    @(posedge clk) disable iff (rst)
      ce && ss_valid && ((ss.mask & ~kill_w) == 4'h0) |=> !disp_valid;
  endproperty
  a_empty_drop: assert property (p_empty_drop)
    else $error("empty subspan dispatched");

  property p_comp_no_kill;
    @(posedge clk) disable iff (rst)
      ce && ss_valid && is_c |=> disp_mask == $past(ss.mask);
  endproperty
  a_comp_no_kill: assert property (p_comp_no_kill)
    else $error("pixel killed early in computed mode");

  property p_stats_ovr;
    @(posedge clk) disable iff (rst)
      ce && stats && kil && tab_early |=> mode == ezt_mode_late_wr
                                          && pay.wo_alloc && pay.src_to_rt;
  endproperty
  a_stats_ovr: assert property (p_stats_ovr)
    else $error("statistics override missing");

  property p_src_present;
    @(posedge clk) disable iff (rst)
      ce && (use_src || (ovr && !cd)) |=> pay.src_present;
  endproperty
  a_src_present: assert property (p_src_present)
    else $error("source depth not flagged present");

  property p_clamp_cap;
    @(posedge clk) disable iff (rst)
      ce && prim_valid && clamp_pos ##1 bias_valid
        |-> !fp_gt(bias, clamp_q);
  endproperty
  a_clamp_cap: assert property (p_clamp_cap)
    else $error("bias above positive clamp");

  property p_no_early_wr_kill;
    @(posedge clk) disable iff (rst)
      ce && kil |=> early_wr == 4'h0;
  endproperty
  a_no_early_wr_kill: assert property (p_no_early_wr_kill)
    else $error("early write while shader may discard");

  property p_stencil_keep;
    @(posedge clk) disable iff (rst)
      ce && ss_valid && sw && !is_p |=> disp_mask == $past(ss.mask);
  endproperty
  a_stencil_keep: assert property (p_stencil_keep)
    else $error("pixel killed with stencil write pending");
endmodule
